/* File: hdl/ras_stack.sv */
// return address stack with pointer status, top entry access and shadow
//
// Contract
// - 31 by 21-bit store, 5-bit pointer
// - calls and interrupts push, returns pop
// - calls and returns leave pc latches alone
// - push increments pointer, then writes pc
// - pop reads entry, then decrements pointer
// - every reset zeroes pointer; zero is empty
// - top entry registers access selected entry only
// - pointer 0 to 31, software readable, writable
// - full flag after 31 pushes, sticky
// - error reset on: store pc+2, reset
// - error reset off: pointer holds at 31
// - pop at zero loads zero, sets underflow
// - full or underflow resets when enabled
// - plain underflow only redirects to zero
// - software push stores pc in new entry
// - software pop only decrements pointer
// - pointer status register bit layout
// - shadow captures status, working, bank on interrupt
// - fast interrupt return restores shadow
// - fast call saves, fast return restores
// - one shadow shared by both priorities
// - pc 21 bits, lsb zero, step 2
//
// Added by the designer: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`include "ras_consts.svh"

module ras_stack (
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	input wire logic dev_rst_in,
	input wire ras_pkg::ras_op_type op_in,
	input wire logic fast_in,
	input wire logic [20:0] pc_in,
	input wire logic [7:0] status_in,
	input wire logic [7:0] working_register_in,
	input wire logic [3:0] bank_select_register_in,
	input wire logic [2:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [7:0] reg_rdata_out,
	output logic pc_load_out,
	output logic [20:0] pc_value_out,
	output logic restore_out,
	output logic [7:0] status_out,
	output logic [7:0] working_register_out,
	output logic [3:0] bank_select_register_out,
	output logic stack_reset_req_out
);

	// ***************************************************************
	// storage and state
	// ***************************************************************

	// entry storage
	// no entry exists behind level zero, so the array starts at one
	logic [20:0] stack_mem [1:31];
	logic [4:0] stack_level_ff;
	logic [4:0] nxt_stack_level;
	logic stack_full_flag_ff;
	logic nxt_stack_full_flag;
	logic stack_underflow_flag_ff;
	logic nxt_stack_underflow_flag;
	logic stack_error_reset_enable_ff;
	logic [7:0] shadow_status_ff;
	logic [7:0] shadow_working_ff;
	logic [3:0] shadow_bank_ff;

	// write port of the store
	logic mem_we;
	logic [4:0] mem_waddr;
	logic [20:0] mem_wdata;

	// decoded requests
	logic is_push;
	logic is_ret;
	logic is_sw_pop;
	logic save_shadow;
	logic do_restore;
	logic sw_access;
	logic [20:0] top_entry;
	logic [20:0] pc_aligned;

	// next values of the answer flops
	logic nxt_pc_load;
	logic [20:0] nxt_pc_value;
	logic nxt_reset_req;
	logic [7:0] nxt_rdata;

	// ***************************************************************
	// request decode
	// ***************************************************************

	assign is_push = (op_in == ras_pkg::op_call) ||
		(op_in == ras_pkg::op_relative_call) ||
		(op_in == ras_pkg::op_int_ack) ||
		(op_in == ras_pkg::op_sw_push);
	assign is_ret = (op_in == ras_pkg::op_return) ||
		(op_in == ras_pkg::op_return_with_literal) ||
		(op_in == ras_pkg::op_return_from_interrupt);
	assign is_sw_pop = (op_in == ras_pkg::op_sw_pop);

	// every interrupt vector fills the shadow
	// fast call saves, fast return restores
	assign save_shadow = (op_in == ras_pkg::op_int_ack) ||
		((op_in == ras_pkg::op_call) && fast_in);
	assign do_restore = fast_in &&
		((op_in == ras_pkg::op_return_from_interrupt) ||
		(op_in == ras_pkg::op_return));

	// software touches pointer and top entry only on idle cycles
	// sequencer wins so a push is never half overwritten
	assign sw_access = reg_wr_in && (op_in == ras_pkg::op_none) &&
		!dev_rst_in;

	// lsb of the pc is always zero
	assign pc_aligned = {pc_in[20:1], 1'b0};

	// level zero has no entry, reads as zero
	assign top_entry = (stack_level_ff == `RAS_RST_LEVEL) ?
		21'h00_0000 : stack_mem[stack_level_ff];

	// ***************************************************************
	// pointer, flags and store write
	// ***************************************************************

	// one decision per cycle for pointer, flags and the write port
	always_comb begin
		nxt_stack_level = stack_level_ff;
		nxt_stack_full_flag = stack_full_flag_ff;
		nxt_stack_underflow_flag = stack_underflow_flag_ff;
		nxt_pc_load = 1'b0;
		nxt_pc_value = 21'h00_0000;
		nxt_reset_req = 1'b0;
		mem_we = 1'b0;
		mem_waddr = stack_level_ff;
		mem_wdata = pc_aligned;

		// writing zero clears a flag, ones are ignored
		if (sw_access && (reg_addr_in == `RAS_OFS_PTR_STATUS)) begin
			if (!reg_wdata_in[`RAS_BIT_FULL]) begin
				nxt_stack_full_flag = 1'b0;
			end
			if (!reg_wdata_in[`RAS_BIT_UNDERFLOW]) begin
				nxt_stack_underflow_flag = 1'b0;
			end
			nxt_stack_level = reg_wdata_in[`RAS_BIT_LEVEL_MSB:0];
		end

		// top entry byte writes, merged into selected word
		if (sw_access && (stack_level_ff != `RAS_RST_LEVEL)) begin
			case (reg_addr_in)
				`RAS_OFS_TOP_LOW: begin
					mem_we = 1'b1;
					mem_wdata = {top_entry[20:8], reg_wdata_in};
				end
				`RAS_OFS_TOP_HIGH: begin
					mem_we = 1'b1;
					mem_wdata = {top_entry[20:16], reg_wdata_in,
						top_entry[7:0]};
				end
				`RAS_OFS_TOP_UPPER: begin
					mem_we = 1'b1;
					mem_wdata = {reg_wdata_in[4:0], top_entry[15:0]};
				end
				default: begin
					mem_we = 1'b0;
				end
			endcase
		end

		if (is_push) begin
			if (stack_level_ff == `RAS_LEVEL_LAST) begin
				// no overwrite, pointer stays at 31 unless error reset is enabled
				nxt_stack_full_flag = 1'b1;
				// a full stack resets when enabled
				nxt_reset_req = stack_error_reset_enable_ff;
				if (stack_error_reset_enable_ff) begin
					nxt_stack_level = `RAS_RST_LEVEL;
				end
			end else if (stack_level_ff == `RAS_LEVEL_BEFORE_LAST) begin
				// the 31st push sets the sticky full flag
				nxt_stack_full_flag = 1'b1;
				mem_we = 1'b1;
				mem_waddr = `RAS_LEVEL_LAST;
				if (stack_error_reset_enable_ff) begin
					// store pc plus 2, then reset
					mem_wdata = pc_aligned + `RAS_PC_STEP;
					nxt_stack_level = `RAS_RST_LEVEL;
					nxt_reset_req = 1'b1;
				end else begin
					mem_wdata = pc_aligned;
					nxt_stack_level = `RAS_LEVEL_LAST;
				end
			end else begin
				// increment first, then write the new entry
				// software push stores the current pc
				nxt_stack_level = stack_level_ff + 5'h01;
				mem_we = 1'b1;
				mem_waddr = stack_level_ff + 5'h01;
				mem_wdata = pc_aligned;
			end
		end else if (is_ret) begin
			nxt_pc_load = 1'b1;
			if (stack_level_ff == `RAS_RST_LEVEL) begin
				// empty pop loads zero and flags underflow
				// without reset this only redirects to zero
				nxt_pc_value = 21'h00_0000;
				nxt_stack_underflow_flag = 1'b1;
				nxt_reset_req = stack_error_reset_enable_ff;
			end else begin
				nxt_pc_value = {top_entry[20:1], 1'b0};
				nxt_stack_level = stack_level_ff - 5'h01;
			end
		end else if (is_sw_pop) begin
			if (stack_level_ff == `RAS_RST_LEVEL) begin
				nxt_stack_underflow_flag = 1'b1;
				nxt_reset_req = stack_error_reset_enable_ff;
			end else begin
				nxt_stack_level = stack_level_ff - 5'h01;
			end
		end

		// any device reset returns the pointer to zero
		// flags survive, only power-on reset or a software write of zero clears them
		if (dev_rst_in) begin
			nxt_stack_level = `RAS_RST_LEVEL;
			nxt_pc_load = 1'b0;
			nxt_reset_req = 1'b0;
			mem_we = 1'b0;
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			stack_level_ff <= `RAS_RST_LEVEL;
		end else begin
			stack_level_ff <= nxt_stack_level;
		end
	end

	// sticky flags, set beats software clear
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			stack_full_flag_ff <= 1'b0;
			stack_underflow_flag_ff <= 1'b0;
		end else begin
			stack_full_flag_ff <= nxt_stack_full_flag;
			stack_underflow_flag_ff <= nxt_stack_underflow_flag;
		end
	end

	// store has no reset, contents are undefined until pushed
	always_ff @(posedge clk_sys_in) begin
		if (mem_we && (mem_waddr != `RAS_RST_LEVEL)) begin
			stack_mem[mem_waddr] <= mem_wdata;
		end
	end

	// error reset enable, written by software, survives device reset
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			stack_error_reset_enable_ff <= `RAS_RST_ERR_RST_EN;
		end else if (reg_wr_in && (reg_addr_in == `RAS_OFS_CTRL)) begin
			stack_error_reset_enable_ff <=
				reg_wdata_in[`RAS_BIT_ERR_RST_EN];
		end
	end

	// ***************************************************************
	// shadow store
	// ***************************************************************

	// single shadow, a later interrupt simply overwrites it
	// not visible on the register port
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			shadow_status_ff <= 8'h00;
			shadow_working_ff <= 8'h00;
			shadow_bank_ff <= 4'h0;
		end else if (save_shadow && !dev_rst_in) begin
			shadow_status_ff <= status_in;
			shadow_working_ff <= working_register_in;
			shadow_bank_ff <= bank_select_register_in;
		end
	end

	// restore values presented one cycle after the return
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			restore_out <= 1'b0;
			status_out <= 8'h00;
			working_register_out <= 8'h00;
			bank_select_register_out <= 4'h0;
		end else begin
			restore_out <= do_restore && !dev_rst_in;
			status_out <= shadow_status_ff;
			working_register_out <= shadow_working_ff;
			bank_select_register_out <= shadow_bank_ff;
		end
	end

	// ***************************************************************
	// answers to the sequencer
	// ***************************************************************

	// only the pc is loaded, pc latches are never driven here
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pc_load_out <= 1'b0;
			pc_value_out <= 21'h00_0000;
			stack_reset_req_out <= 1'b0;
		end else begin
			pc_load_out <= nxt_pc_load;
			pc_value_out <= nxt_pc_value;
			stack_reset_req_out <= nxt_reset_req;
		end
	end

	// ***************************************************************
	// register read port
	// ***************************************************************

	// pointer status layout, bit 5 reads zero
	always_comb begin
		nxt_rdata = 8'h00;
		if (reg_rd_in) begin
			case (reg_addr_in)
				`RAS_OFS_PTR_STATUS: begin
					nxt_rdata = {stack_full_flag_ff,
						stack_underflow_flag_ff, 1'b0, stack_level_ff};
				end
				`RAS_OFS_TOP_LOW: begin
					nxt_rdata = top_entry[7:0];
				end
				`RAS_OFS_TOP_HIGH: begin
					nxt_rdata = top_entry[15:8];
				end
				`RAS_OFS_TOP_UPPER: begin
					nxt_rdata = {3'h0, top_entry[20:16]};
				end
				`RAS_OFS_CTRL: begin
					nxt_rdata = {7'h00, stack_error_reset_enable_ff};
				end
				default: begin
					nxt_rdata = 8'h00;
				end
			endcase
		end
	end

	// read data stand one cycle, zero otherwise
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			reg_rdata_out <= 8'h00;
		end else begin
			reg_rdata_out <= nxt_rdata;
		end
	end

endmodule

/* File: hdl/ras_consts.svh */
// offsets, field positions, reset values and counts of the return stack
`ifndef RAS_CONSTS_SVH
`define RAS_CONSTS_SVH

// register port offsets
`define RAS_OFS_PTR_STATUS 3'h0
`define RAS_OFS_TOP_LOW 3'h1
`define RAS_OFS_TOP_HIGH 3'h2
`define RAS_OFS_TOP_UPPER 3'h3
`define RAS_OFS_CTRL 3'h4

// pointer status fields
`define RAS_BIT_FULL 7
`define RAS_BIT_UNDERFLOW 6
`define RAS_BIT_LEVEL_MSB 4

// control register fields
`define RAS_BIT_ERR_RST_EN 0

// reset values
`define RAS_RST_LEVEL 5'h00
`define RAS_RST_ERR_RST_EN 1'b1

// stack geometry and program counter step
`define RAS_LEVEL_LAST 5'h1f
`define RAS_LEVEL_BEFORE_LAST 5'h1e
`define RAS_PC_STEP 21'h00_0002

`endif

/* File: hdl/ras_pkg.sv */
// types shared by the return address stack
package ras_pkg;

	// request from the instruction sequencer, one cycle each
	typedef enum logic [3:0] {
		op_none,
		op_call,
		op_relative_call,
		op_int_ack,
		op_return,
		op_return_with_literal,
		op_return_from_interrupt,
		op_sw_push,
		op_sw_pop
	} ras_op_type;

endpackage

/* File: verif/ras_stack_monitor.sv */
// port checker of the return address stack
`timescale 1ns/1ps
module ras_stack_monitor (
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	input wire logic dev_rst_in,
	input wire ras_pkg::ras_op_type op_in,
	input wire logic fast_in,
	input wire logic [7:0] status_in,
	input wire logic [2:0] reg_addr_in,
	input wire logic reg_rd_in,
	input wire logic [7:0] reg_rdata_out,
	input wire logic pc_load_out,
	input wire logic [20:0] pc_value_out,
	input wire logic restore_out,
	input wire logic [7:0] status_out,
	input wire logic stack_reset_req_out
);
	// *****
	// steps
	// *****
	default clocking @(posedge clk_sys_in);
	endclocking
	default disable iff (!rst_n_in);
	// device reset swallows the op of its cycle except for its full or underflow flag update
	sequence s_pop;
		!dev_rst_in && op_in inside {ras_pkg::op_return,
			ras_pkg::op_return_with_literal,
			ras_pkg::op_return_from_interrupt};
	endsequence
	sequence s_fast_ret;
		!dev_rst_in && fast_in && op_in inside {ras_pkg::op_return,
			ras_pkg::op_return_from_interrupt};
	endsequence
	sequence s_save;
		!dev_rst_in && (op_in == ras_pkg::op_int_ack ||
			(fast_in && op_in == ras_pkg::op_call));
	endsequence
	// **********
	// assertions
	// **********
	chk_pop_loads_pc: assert property (s_pop |=> pc_load_out)
		else $error("return without pc load");
	chk_sw_pop_quiet: assert property (
		op_in == ras_pkg::op_sw_pop |=> !pc_load_out)
		else $error("software pop loaded pc");
	chk_idle_quiet: assert property (
		op_in == ras_pkg::op_none
		|=> !pc_load_out && !restore_out && !stack_reset_req_out)
		else $error("pulse without request");
	chk_pc_even: assert property (
		pc_load_out |-> pc_value_out[0] == 1'b0)
		else $error("odd pc loaded");
	chk_fast_restore: assert property (s_fast_ret |=> restore_out)
		else $error("fast return without restore");
	chk_shadow_value: assert property (
		s_save ##1 s_fast_ret |=> status_out == $past(status_in, 2))
		else $error("restored status differs");
	chk_bit5_zero: assert property (
		reg_rd_in && reg_addr_in == 3'h0 |=> !reg_rdata_out[5])
		else $error("pointer bit 5 set");
	chk_literal_plain: assert property (
		op_in == ras_pkg::op_return_with_literal |=> !restore_out)
		else $error("literal return restored");
	// read data stand only in the cycle after the strobe
	chk_rdata_idle: assert property (
		!reg_rd_in |=> reg_rdata_out == 8'h00)
		else $error("read data without read strobe");
endmodule

bind ras_stack ras_stack_monitor i_mon (
	.clk_sys_in(clk_sys_in),
	.rst_n_in(rst_n_in),
	.dev_rst_in(dev_rst_in),
	.op_in(op_in),
	.fast_in(fast_in),
	.status_in(status_in),
	.reg_addr_in(reg_addr_in),
	.reg_rd_in(reg_rd_in),
	.reg_rdata_out(reg_rdata_out),
	.pc_load_out(pc_load_out),
	.pc_value_out(pc_value_out),
	.restore_out(restore_out),
	.status_out(status_out),
	.stack_reset_req_out(stack_reset_req_out)
);

/* File: verif/ras_seq_model.sv */
// stand-in for the instruction sequencer facing the stack
`timescale 1ns/1ps
module ras_seq_model (
	input wire logic clk_sys_in,
	output ras_pkg::ras_op_type op_out,
	output logic fast_out,
	output logic [20:0] pc_out,
	output logic [19:0] shadow_out
);
	// *******
	// request
	// *******
	// idle from time zero
	initial begin
		op_out = ras_pkg::op_none;
		fast_out = 1'b0;
		pc_out = 21'h00_0000;
		shadow_out = 20'h0_0000;
	end
	// held until the next call, so ops may run back to back
	task automatic issue(input ras_pkg::ras_op_type o, input logic f,
		input logic [20:0] p, input logic [19:0] s);
		@(posedge clk_sys_in);
		op_out <= o;
		fast_out <= f;
		pc_out <= p;
		shadow_out <= s;
	endtask
endmodule

/* File: verif/return_address_stack_bench.sv */
// self-checking bench of the return address stack
`timescale 1ns/1ps
`define CK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
	miscompares++; \
	$display("unexpected %s exp %h got %h", n, e, g); end end
module return_address_stack_bench;
	logic clk_sys_in, rst_n_in, dev_rst_in, fast_in, reg_wr_in, reg_rd_in;
	logic pc_load_out, restore_out, stack_reset_req_out, rd_d;
	ras_pkg::ras_op_type op_in;
	logic [20:0] pc_in, pc_value_out;
	logic [7:0] status_in, working_register_in, reg_wdata_in;
	logic [7:0] reg_rdata_out, status_out, working_register_out;
	logic [3:0] bank_select_register_in, bank_select_register_out;
	logic [2:0] reg_addr_in;
	logic [22:0] notes[$];
	int miscompares, samples_checked;
	localparam logic [20:0] even_mask = 21'h1f_fffe;
	ras_stack i_dut (.*);
	ras_seq_model i_seq (.clk_sys_in(clk_sys_in), .op_out(op_in),
		.fast_out(fast_in), .pc_out(pc_in), .shadow_out({status_in,
		working_register_in, bank_select_register_in}));
	// *****
	// tasks
	// *****
	task automatic note(input logic [1:0] k, input logic [20:0] v);
		notes.push_back({k, v});
	endtask
	task automatic go(input ras_pkg::ras_op_type o, input logic f,
		input logic [20:0] p, input logic [19:0] s);
		i_seq.issue(o, f, p, s);
	endtask
	// register access first drives the sequencer idle, then strobes one cycle later
	task automatic acc(input logic [2:0] a, input logic [7:0] d,
		input logic w);
		go(ras_pkg::op_none, 1'b0, 21'h0, 20'h0);
		@(posedge clk_sys_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_wr_in <= w;
		reg_rd_in <= !w;
		@(posedge clk_sys_in);
		reg_wr_in <= 1'b0;
		reg_rd_in <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a, input logic [7:0] e);
		note(2'h0, {13'h0, e});
		acc(a, 8'h00, 1'b0);
	endtask
	task automatic take(input logic [1:0] k, input logic [20:0] g);
		logic [22:0] e;
		string n;
		e = notes.size() ? notes.pop_front() : 23'h7f_ffff;
		n = (k == 2'h0) ? "read_data" : (k == 2'h1) ? "pc_value" :
			(k == 2'h2) ? "reset_request" : "restored_shadow";
		`CK(n, e, {k, g})
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// *******
	// results
	// *******
	// clock and hang guard
	initial begin
		clk_sys_in = 1'b0;
		forever #10 clk_sys_in = ~clk_sys_in;
	end
	initial begin
		repeat (5000) @(posedge clk_sys_in);
		miscompares++;
		close_out();
	end
	// settled outputs checked on the falling edge, oldest note first
	always @(posedge clk_sys_in) rd_d <= reg_rd_in;
	always @(negedge clk_sys_in) begin
		if (rd_d) take(2'h0, {13'h0, reg_rdata_out});
		if (pc_load_out) take(2'h1, pc_value_out);
		if (stack_reset_req_out) take(2'h2, 21'h0);
		if (restore_out) take(2'h3, {1'b0, status_out,
			working_register_out, bank_select_register_out});
	end
	// ********
	// sequence
	// ********
	initial begin
		logic [20:0] pa, pb, pv;
		logic [19:0] sa, sb;
		int seed;
		rst_n_in = 1'b0;
		dev_rst_in = 1'b0;
		reg_addr_in = 3'h0;
		reg_wdata_in = 8'h00;
		reg_wr_in = 1'b0;
		reg_rd_in = 1'b0;
		seed = 1412;
		pa = 21'($random(seed));
		pb = 21'($random(seed));
		pv = 21'($random(seed));
		sa = 20'($random(seed));
		sb = 20'($random(seed));
		repeat (4) @(posedge clk_sys_in);
		rst_n_in <= 1'b1;
		rd(3'h0, 8'h00);
		rd(3'h4, 8'h01);
		rd(3'h5, 8'h00);
		rd(3'h1, 8'h00);
		acc(3'h4, 8'h00, 1'b1);
		// call, relative call and interrupt pushes, then the top bytes
		go(ras_pkg::op_call, 1'b0, pa, sa);
		go(ras_pkg::op_relative_call, 1'b0, pb, sa);
		go(ras_pkg::op_int_ack, 1'b0, pv, sa);
		rd(3'h0, 8'h03);
		rd(3'h1, pv[7:0] & 8'hfe);
		rd(3'h2, pv[15:8]);
		rd(3'h3, {3'h0, pv[20:16]});
		acc(3'h1, 8'h44, 1'b1);
		// every pop kind down into underflow
		note(2'h1, {pv[20:8], 8'h44});
		go(ras_pkg::op_return, 1'b0, 21'h0, 20'h0);
		note(2'h1, pb & even_mask);
		go(ras_pkg::op_return_with_literal, 1'b0, 21'h0, 20'h0);
		go(ras_pkg::op_sw_pop, 1'b0, 21'h0, 20'h0);
		note(2'h1, 21'h0);
		go(ras_pkg::op_return_from_interrupt, 1'b0, 21'h0, 20'h0);
		rd(3'h0, 8'h40);
		acc(3'h0, 8'h00, 1'b1);
		rd(3'h0, 8'h00);
		// one shadow shared by fast call and interrupt
		go(ras_pkg::op_call, 1'b1, pa, sa);
		go(ras_pkg::op_int_ack, 1'b0, pb, sb);
		note(2'h1, pb & even_mask);
		note(2'h3, {1'b0, sb});
		go(ras_pkg::op_return, 1'b1, 21'h0, 20'h0);
		go(ras_pkg::op_int_ack, 1'b0, pv, sa);
		note(2'h1, pv & even_mask);
		note(2'h3, {1'b0, sa});
		go(ras_pkg::op_return_from_interrupt, 1'b1, 21'h0, 20'h0);
		note(2'h1, pa & even_mask);
		note(2'h3, {1'b0, sa});
		go(ras_pkg::op_return_from_interrupt, 1'b1, 21'h0, 20'h0);
		// fill without error reset, one push refused
		for (int i = 1; i < 32; i++) begin
			go(ras_pkg::op_sw_push, 1'b0, 21'(i * 4), 20'h0);
		end
		go(ras_pkg::op_call, 1'b0, 21'h00_0002, 20'h0);
		rd(3'h0, 8'h9f);
		rd(3'h1, 8'h7c);
		acc(3'h0, 8'h1f, 1'b1);
		rd(3'h0, 8'h1f);
		// 31st push with error reset on
		acc(3'h4, 8'h01, 1'b1);
		acc(3'h0, 8'h1e, 1'b1);
		note(2'h2, 21'h0);
		go(ras_pkg::op_call, 1'b0, pa, 20'h0);
		rd(3'h0, 8'h80);
		acc(3'h0, 8'h9f, 1'b1);
		rd(3'h1, 8'((pa & even_mask) + 21'h2));
		@(posedge clk_sys_in);
		dev_rst_in <= 1'b1;
		@(posedge clk_sys_in);
		dev_rst_in <= 1'b0;
		rd(3'h0, 8'h80);
		note(2'h1, 21'h0);
		note(2'h2, 21'h0);
		go(ras_pkg::op_return, 1'b0, 21'h0, 20'h0);
		rd(3'h0, 8'hc0);
		// power-on reset clears the flags
		@(posedge clk_sys_in);
		rst_n_in <= 1'b0;
		@(posedge clk_sys_in);
		rst_n_in <= 1'b1;
		rd(3'h0, 8'h00);
		repeat (4) @(posedge clk_sys_in);
		if (notes.size() != 0) miscompares++;
		close_out();
	end
endmodule
